// *** common/pio_pkg.sv ***
// Package for the port cell block: register map, reset values, widths and carrier types.
// Assumes one AHB-Lite slave select and 32-bit word-aligned registers.
package pio_pkg;

    // -------------------------------------------------------------------------
    // Sizes
    // -------------------------------------------------------------------------
    localparam int PIO_NPINS = 17;            // Port 0, port 1 and the single port 2 pin
    localparam int PIO_NXPINS = 16;           // Pins that the crossbar may route
    localparam int PIO_NRES = 16;             // Routable internal resources
    localparam int PIO_UART_TX_PIN = 4;       // Fixed serial transmit pin
    localparam int PIO_UART_RX_PIN = 5;       // Fixed serial receive pin
    localparam int PIO_DBG_PIN = 16;          // Port 2 pin shared with the debug link

    // -------------------------------------------------------------------------
    // Register offsets (byte addresses)
    // -------------------------------------------------------------------------
    localparam logic [7:0] PIO_CTRL_OFS = 8'h00;      // crossbar_enable, global_pullup_disable
    localparam logic [7:0] PIO_INMODE_OFS = 8'h04;    // pin_input_mode_bits
    localparam logic [7:0] PIO_OUTMODE_OFS = 8'h08;   // pin_output_mode_bits
    localparam logic [7:0] PIO_OUTVAL_OFS = 8'h0C;    // Output latch
    localparam logic [7:0] PIO_PINREAD_OFS = 8'h10;   // Pad levels, read only
    localparam logic [7:0] PIO_SKIP_OFS = 8'h14;      // pin_skip_bits
    localparam logic [7:0] PIO_ROUTE1_OFS = 8'h18;    // route_select_first
    localparam logic [7:0] PIO_ROUTE2_OFS = 8'h1C;    // route_select_second

    // -------------------------------------------------------------------------
    // Field positions and reset values
    // -------------------------------------------------------------------------
    localparam int PIO_CTRL_XBAR_BIT = 0;
    localparam int PIO_CTRL_GPD_BIT = 1;
    localparam int PIO_ROUTE_UART_BIT = 0;
    localparam logic [16:0] PIO_INMODE_RST = 17'h1FFFF;   // 1 = digital
    localparam logic [16:0] PIO_OUTMODE_RST = 17'h00000;  // 0 = open drain
    localparam logic [16:0] PIO_OUTVAL_RST = 17'h1FFFF;
    localparam logic [15:0] PIO_SKIP_RST = 16'h0000;
    localparam logic [7:0] PIO_ROUTE_RST = 8'h00;
    localparam logic [15:0] PIO_UART_MASK = 16'h0030;     // Pins 4 and 5

    // -------------------------------------------------------------------------
    // Carrier types
    // -------------------------------------------------------------------------
    // Pad drive bundle, one bit per pin
    typedef struct packed {
        logic [16:0] out;   // Driven level
        logic [16:0] oe;    // High while the cell drives the pad
        logic [16:0] pu;    // Weak pull-up enable
    } pio_pad_t;

    // Internal resource drive bundle
    typedef struct packed {
        logic [15:0] out;   // Resource output level
        logic [15:0] oe;    // Resource wants to drive its pin
    } pio_res_t;

endpackage : pio_pkg

// *** logic/pio_sync2.sv ***
// Two-stage synchroniser for a bus of asynchronous levels.
// Assumes the inputs are quasi-static levels; no word coherence is promised.
`timescale 1ns/10ps
module pio_sync2 #(
    parameter int WIDTH = 17
) (
    // Clock and reset
    input wire logic hclk,
    input wire logic hresetn,
    // Data
    input wire logic [WIDTH-1:0] async_in,
    output logic [WIDTH-1:0] sync_out
);

    // First stage, read only by the second stage
    logic [WIDTH-1:0] meta_ff;

    // -------------------------------------------------------------------------
    // Two flip-flops in series
    // -------------------------------------------------------------------------
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            meta_ff <= '0;
            sync_out <= '0;
        end else begin
            meta_ff <= async_in;
            sync_out <= meta_ff;
        end
    end

endmodule : pio_sync2

// *** logic/pio_cell_top.sv ***
// Port input/output cell block: 17 pad cells, crossbar routing and AHB-Lite registers.
// Assumes pads are resolved outside from out/oe/pu; pad inputs are asynchronous.
//
// Notes on behaviour
// - Reset: all cells hi-Z, pull-up on
// - Per-pin input mode picks analog or digital
// - Analog pin: driver, receiver off; pull-up off once crossbar on; res_in, uart_rx still see its pad
// - Analog pin always reads zero
// - Per-pin output mode bits for ports 0,1 and the port 2 pin
// - Push-pull pin drives high or low
// - Open-drain: never high, low or released
// - Pull-up on when hi-Z, off driving low
// - Global pull-up disable turns all off
// - Digital pin reads pad level, not latch
// - Pin read ignores crossbar routing
// - Seventeen pins, GPIO or resource or analog
// - Port 2 pin GPIO only, shares debug data
// - Crossbar routes selected resources by priority
// - Lowest free unskipped pin; serial fixed 4,5
`timescale 1ns/10ps
module pio_cell_top (
    // Clock and reset
    input wire logic hclk,
    input wire logic hresetn,
    // AHB-Lite slave
    input wire logic hsel,
    input wire logic [7:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [2:0] hsize,
    input wire logic [31:0] hwdata,
    input wire logic hready,
    output logic hreadyout,
    output logic hresp,
    output logic [31:0] hrdata,
    // Pads
    input wire logic [16:0] pad_in,
    output pio_pkg::pio_pad_t pad,
    // Internal resources
    input wire pio_pkg::pio_res_t res_drv,
    output logic [15:0] res_in,
    output logic uart_rx,
    // Debug link sharing the port 2 pin
    input wire logic dbg_active,
    input wire logic dbg_out,
    input wire logic dbg_oe
);

    // -------------------------------------------------------------------------
    // State
    // -------------------------------------------------------------------------
    typedef struct packed {
        logic xbar_en;              // crossbar_enable
        logic gpd;                  // global_pullup_disable
        logic [16:0] in_mode;       // 1 = digital, 0 = analog
        logic [16:0] out_mode;      // 1 = push-pull, 0 = open drain
        logic [16:0] out_val;       // Output latch
        logic [15:0] skip;          // Pins the crossbar passes over
        logic [7:0] route1;         // Resources 0..7
        logic [7:0] route2;         // Resources 8..15
        logic wr_pend;              // Write data phase due
        logic [7:0] wr_addr;        // Address of that write
        logic [31:0] rdata;         // Read data for the data phase
        pio_pkg::pio_pad_t pad;     // Registered pad drive
        logic [15:0] res_in;        // Registered resource inputs
        logic uart_rx;              // Registered serial receive level
    } pio_state_t;

    pio_state_t s_ff;               // Current state
    pio_state_t nxt_s;              // Next state
    logic [16:0] pin_lvl;           // Synchronised pad levels
    logic [16:0] pin_read;          // Readable levels, analog masked
    logic [15:0] res_valid;         // Resource holds a pin
    logic [3:0] res_pin [16];       // Pin held by each resource
    logic [15:0] res_sel;           // Resources software selected
    logic addr_ok;                  // Valid address phase

    // -------------------------------------------------------------------------
    // Pad input synchroniser
    // -------------------------------------------------------------------------
    pio_sync2 #(
        .WIDTH(pio_pkg::PIO_NPINS)
    ) u_sync (
        .hclk(hclk),
        .hresetn(hresetn),
        .async_in(pad_in),
        .sync_out(pin_lvl)
    );

    // Analog receivers are off, so their reads are zero; routing plays no part
    assign pin_read = pin_lvl & s_ff.in_mode;

    // -------------------------------------------------------------------------
    // Crossbar assignment
    // -------------------------------------------------------------------------
    assign res_sel = {s_ff.route2, s_ff.route1};

    // Walk resources in priority order, each after the serial port taking the lowest free pin
    // Pins can run out before resources do: a resource left without a pin
    // stays internal, drives nothing and reads zero on res_in
    always_comb begin
        logic [15:0] taken;
        logic found;
        taken = s_ff.skip;
        found = 1'b0;
        res_valid = '0;
        for (int r = 0; r < pio_pkg::PIO_NRES; r++) begin
            res_pin[r] = 4'h0;
        end
        // Serial port always sits on its fixed pair
        if (res_sel[pio_pkg::PIO_ROUTE_UART_BIT]) begin
            res_valid[0] = 1'b1;
            res_pin[0] = 4'(pio_pkg::PIO_UART_TX_PIN);
            taken = taken | pio_pkg::PIO_UART_MASK;
        end
        for (int r = 1; r < pio_pkg::PIO_NRES; r++) begin
            found = 1'b0;
            // Selected resources only
            if (res_sel[r]) begin
                for (int p = 0; p < pio_pkg::PIO_NXPINS; p++) begin
                    // First pin neither skipped nor taken
                    if (!found && !taken[p]) begin
                        found = 1'b1;
                        res_valid[r] = 1'b1;
                        res_pin[r] = 4'(p);
                        taken[p] = 1'b1;
                    end
                end
            end
        end
    end

    // -------------------------------------------------------------------------
    // Next state: bus, registers, pad drive
    // -------------------------------------------------------------------------
    assign addr_ok = hsel && htrans[1] && hready;

    always_comb begin
        logic [16:0] val;
        logic [15:0] rin;
        val = s_ff.out_val;
        rin = '0;
        nxt_s = s_ff;
        // Write data phase lands in the addressed register
        if (s_ff.wr_pend) begin
            case (s_ff.wr_addr)
                pio_pkg::PIO_CTRL_OFS: begin
                    nxt_s.xbar_en = hwdata[pio_pkg::PIO_CTRL_XBAR_BIT];
                    nxt_s.gpd = hwdata[pio_pkg::PIO_CTRL_GPD_BIT];
                end
                pio_pkg::PIO_INMODE_OFS: begin
                    nxt_s.in_mode = hwdata[16:0];
                end
                pio_pkg::PIO_OUTMODE_OFS: begin
                    nxt_s.out_mode = hwdata[16:0];
                end
                pio_pkg::PIO_OUTVAL_OFS: begin
                    nxt_s.out_val = hwdata[16:0];
                end
                pio_pkg::PIO_SKIP_OFS: begin
                    nxt_s.skip = hwdata[15:0];
                end
                pio_pkg::PIO_ROUTE1_OFS: begin
                    nxt_s.route1 = hwdata[7:0];
                end
                pio_pkg::PIO_ROUTE2_OFS: begin
                    nxt_s.route2 = hwdata[7:0];
                end
                default: begin
                    // Unmapped or read-only: ignored
                end
            endcase
        end
        // Address phase: note writes, fetch read data for the next cycle
        nxt_s.wr_pend = addr_ok && hwrite;
        nxt_s.wr_addr = haddr;
        if (addr_ok && !hwrite) begin
            case (haddr)
                pio_pkg::PIO_CTRL_OFS: begin
                    nxt_s.rdata = {30'h0, s_ff.gpd, s_ff.xbar_en};
                end
                pio_pkg::PIO_INMODE_OFS: begin
                    nxt_s.rdata = {15'h0, s_ff.in_mode};
                end
                pio_pkg::PIO_OUTMODE_OFS: begin
                    nxt_s.rdata = {15'h0, s_ff.out_mode};
                end
                pio_pkg::PIO_OUTVAL_OFS: begin
                    nxt_s.rdata = {15'h0, s_ff.out_val};
                end
                pio_pkg::PIO_PINREAD_OFS: begin
                    nxt_s.rdata = {15'h0, pin_read};
                end
                pio_pkg::PIO_SKIP_OFS: begin
                    nxt_s.rdata = {16'h0, s_ff.skip};
                end
                pio_pkg::PIO_ROUTE1_OFS: begin
                    nxt_s.rdata = {24'h0, s_ff.route1};
                end
                pio_pkg::PIO_ROUTE2_OFS: begin
                    nxt_s.rdata = {24'h0, s_ff.route2};
                end
                default: begin
                    nxt_s.rdata = 32'h0;
                end
            endcase
        end
        // Routed pins take the resource level; a non-driving resource sets it high
        for (int r = 0; r < pio_pkg::PIO_NRES; r++) begin
            if (res_valid[r]) begin
                val[res_pin[r]] = res_drv.out[r] | ~res_drv.oe[r];
                rin[r] = pin_lvl[res_pin[r]];
            end
        end
        // Serial receive pin is an input of the serial port
        if (res_valid[0]) begin
            val[pio_pkg::PIO_UART_RX_PIN] = 1'b1;
        end
        nxt_s.res_in = rin;
        nxt_s.uart_rx = pin_lvl[pio_pkg::PIO_UART_RX_PIN] & res_valid[0];
        // Per-cell drive
        for (int p = 0; p < pio_pkg::PIO_NPINS; p++) begin
            if (!s_ff.xbar_en) begin
                // Held hi-Z, pulled up unless globally disabled, until the crossbar is enabled
                nxt_s.pad.oe[p] = 1'b0;
                nxt_s.pad.out[p] = 1'b0;
            end else if (!s_ff.in_mode[p]) begin
                // Analog: driver off
                nxt_s.pad.oe[p] = 1'b0;
                nxt_s.pad.out[p] = 1'b0;
            end else if (s_ff.out_mode[p]) begin
                // Push-pull follows the output value
                nxt_s.pad.oe[p] = 1'b1;
                nxt_s.pad.out[p] = val[p];
            end else begin
                // Open drain pulls low or lets go
                nxt_s.pad.oe[p] = ~val[p];
                nxt_s.pad.out[p] = 1'b0;
            end
        end
        // Port 2 pin: never routed, debug link takes it while active
        if (dbg_active) begin
            nxt_s.pad.oe[pio_pkg::PIO_DBG_PIN] = dbg_oe;
            nxt_s.pad.out[pio_pkg::PIO_DBG_PIN] = dbg_out;
        end
        // Weak pull-ups: only on released cells, digital ones once the crossbar is on, globally gated
        for (int p = 0; p < pio_pkg::PIO_NPINS; p++) begin
            nxt_s.pad.pu[p] = ~nxt_s.pad.oe[p] & ~s_ff.gpd
                & (s_ff.in_mode[p] | ~s_ff.xbar_en);
        end
    end

    // -------------------------------------------------------------------------
    // State register
    // -------------------------------------------------------------------------
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            s_ff.xbar_en <= 1'b0;
            s_ff.gpd <= 1'b0;
            s_ff.in_mode <= pio_pkg::PIO_INMODE_RST;
            s_ff.out_mode <= pio_pkg::PIO_OUTMODE_RST;
            s_ff.out_val <= pio_pkg::PIO_OUTVAL_RST;
            s_ff.skip <= pio_pkg::PIO_SKIP_RST;
            s_ff.route1 <= pio_pkg::PIO_ROUTE_RST;
            s_ff.route2 <= pio_pkg::PIO_ROUTE_RST;
            s_ff.wr_pend <= 1'b0;
            s_ff.wr_addr <= 8'h00;
            s_ff.rdata <= 32'h0;
            s_ff.pad.out <= 17'h00000;
            s_ff.pad.oe <= 17'h00000;
            s_ff.pad.pu <= 17'h1FFFF;
            s_ff.res_in <= 16'h0000;
            s_ff.uart_rx <= 1'b0;
        end else begin
            s_ff <= nxt_s;
        end
    end

    // -------------------------------------------------------------------------
    // Outputs
    // -------------------------------------------------------------------------
    assign hreadyout = 1'b1;        // Zero wait states
    assign hresp = 1'b0;            // Always OKAY
    assign hrdata = s_ff.rdata;
    assign pad = s_ff.pad;
    assign res_in = s_ff.res_in;
    assign uart_rx = s_ff.uart_rx;

    // -------------------------------------------------------------------------
    // Checks
    // -------------------------------------------------------------------------
    default clocking cb @(posedge hclk);
    endclocking
    default disable iff (!hresetn);

    // Pad drive checks
    pre_xbar_hiz_a: assert property (!s_ff.xbar_en |=> pad.oe[15:0] == 16'h0000)
        else $error("cell driven before crossbar enable");
    pre_xbar_pull_a: assert property ((!s_ff.xbar_en && !s_ff.gpd) |=> pad.pu[15:0] == 16'hFFFF)
        else $error("pull-up missing before crossbar enable");
    analog_off_a: assert property (1'b1 |=> ((pad.oe[15:0] | pad.pu[15:0])
        & ~$past(s_ff.in_mode[15:0]) & {16{$past(s_ff.xbar_en)}}) == 16'h0000)
        else $error("analog cell not isolated");
    // Read path, drive mode, pull-up, debug link and routing checks
    analog_read_a: assert property ((addr_ok && !hwrite && haddr == pio_pkg::PIO_PINREAD_OFS)
        |=> (hrdata[16:0] & ~$past(s_ff.in_mode)) == 17'h00000)
        else $error("analog pin read not zero");
    pad_read_a: assert property ((addr_ok && !hwrite && $past(hresetn, 2)
        && haddr == pio_pkg::PIO_PINREAD_OFS)
        |=> hrdata[16:0] == ($past(pad_in, 3) & $past(s_ff.in_mode)))
        else $error("pin read differs from pad level");
    push_pull_a: assert property (s_ff.xbar_en |=> (pad.oe[15:0]
        | ~$past(s_ff.in_mode[15:0] & s_ff.out_mode[15:0])) == 16'hFFFF)
        else $error("push-pull cell not driving");
    open_drain_a: assert property (1'b1 |=> (pad.oe[15:0] & pad.out[15:0]
        & ~$past(s_ff.out_mode[15:0])) == 16'h0000)
        else $error("open-drain cell drove high");
    pull_low_off_a: assert property ((pad.pu & pad.oe & ~pad.out) == 17'h00000)
        else $error("pull-up on while driving low");
    global_pud_a: assert property (s_ff.gpd |=> pad.pu == 17'h00000)
        else $error("pull-up on under global disable");
    uart_fixed_a: assert property ((s_ff.xbar_en && s_ff.route1[0]) |->
        res_pin[0] == 4'(pio_pkg::PIO_UART_TX_PIN))
        else $error("serial port not on fixed pins");
    debug_pin_a: assert property (dbg_active |=> (pad.oe[16] == $past(dbg_oe))
        && (pad.out[16] == $past(dbg_out)))
        else $error("debug link lost the port 2 pin");
    sync_delay_a: assert property ($past(hresetn, 2) |-> pin_lvl == $past(pad_in, 2))
        else $error("pad level skipped the synchroniser");
    route_order_a: assert property ((res_valid[1] && res_valid[2]) |->
        res_pin[1] < res_pin[2])
        else $error("crossbar priority order broken");

    // Coverage of the main scenarios
    xbar_on_c: cover property (!s_ff.xbar_en ##1 s_ff.xbar_en);
    route_two_c: cover property (s_ff.xbar_en && res_valid[1] && res_valid[2]);
    od_release_c: cover property (s_ff.xbar_en && pad.pu[0] && !pad.oe[0]);
    pin_read_c: cover property (addr_ok && !hwrite && haddr == pio_pkg::PIO_PINREAD_OFS);
    debug_pin_c: cover property (dbg_active && dbg_oe && s_ff.xbar_en);

endmodule : pio_cell_top

// *** verification/pio_pad_env.sv ***
// Pad environment: resolves each pad wire from cell drive, outside drive and pull-up.
// Assumes the bench sets the outside drive; a pad nobody holds toggles every cycle.
`timescale 1ns/10ps
module pio_pad_env (
    // Clock
    input wire logic hclk,
    // Cell and outside drive
    input wire pio_pkg::pio_pad_t pad,
    input wire logic [16:0] ext_val,
    input wire logic [16:0] ext_oe,
    // Resolved pad levels
    output logic [16:0] pad_lvl
);
    // -------------------------------------------------------------------------
    // Resolution
    // -------------------------------------------------------------------------
    logic flt_ff; // Floating pattern, so an undriven pad never looks stable
    initial flt_ff = 1'b0;
    // Toggle the floating pattern
    always @(posedge hclk) begin
        flt_ff <= ~flt_ff;
    end
    // Cell drive first, then outside drive, then pull-up, else floating
    always_comb begin
        for (int i = 0; i < 17; i++) begin
            pad_lvl[i] = pad.oe[i] ? pad.out[i] : ext_oe[i] ? ext_val[i] :
                         pad.pu[i] ? 1'b1 : flt_ff;
        end
    end
endmodule : pio_pad_env

// *** verification/tb_top.sv ***
// Testbench for the port cell block: AHB-Lite master, pad environment, register model.
// Assumes hreadyout feeds hready and the register map of the package.
`timescale 1ns/10ps
module tb_top;
    // -------------------------------------------------------------------------
    // Signals
    // -------------------------------------------------------------------------
    logic hclk, hresetn, hsel, hwrite, hreadyout, hresp, uart_rx;
    logic dbg_active, dbg_out, dbg_oe;
    logic [7:0] haddr;
    logic [1:0] htrans;
    logic [2:0] hsize;
    logic [31:0] hwdata, hrdata;
    logic [16:0] pad_lvl, ext_val, ext_oe;
    logic [15:0] res_in;
    pio_pkg::pio_pad_t pad;
    pio_pkg::pio_res_t res_drv;
    int miscompares, num_checks;
    logic [31:0] m [8]; // Model registers by word index
    logic [31:0] mk [8] = '{32'h3, 32'h1FFFF, 32'h1FFFF, 32'h1FFFF, 32'h0, 32'hFFFF,
                            32'hFF, 32'hFF}; // Writable bits
    logic [31:0] r;
    // -------------------------------------------------------------------------
    // Instances
    // -------------------------------------------------------------------------
    pio_cell_top pio_cell_top_inst (.hclk(hclk), .hresetn(hresetn), .hsel(hsel),
        .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata),
        .hready(hreadyout), .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata),
        .pad_in(pad_lvl), .pad(pad), .res_drv(res_drv), .res_in(res_in), .uart_rx(uart_rx),
        .dbg_active(dbg_active), .dbg_out(dbg_out), .dbg_oe(dbg_oe));
    pio_pad_env pio_pad_env_inst (.hclk(hclk), .pad(pad), .ext_val(ext_val),
        .ext_oe(ext_oe), .pad_lvl(pad_lvl));
    // Clock at 8 ns
    initial begin
        hclk = 1'b0;
        forever #4 hclk = ~hclk;
    end
    // -------------------------------------------------------------------------
    // Tasks
    // -------------------------------------------------------------------------
    // Verdict and end of run
    task automatic complete_run();
        $display("checks %0d mismatches %0d", num_checks, miscompares);
        if (miscompares == 0 && num_checks > 0) $display("No errors found");
        else $display("Errors were found");
        $finish;
    endtask : complete_run
    // Compare seen against expected
    task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
        num_checks++;
        if (seen !== exp) begin
            miscompares++;
            $display("[FAIL] %s expected %h seen %h", nm, exp, seen);
        end
    endtask : chk
    // One single AHB-Lite transfer, entered just after a rising edge
    task automatic ahb(input bit w, input logic [7:0] a, input logic [31:0] d,
                       output logic [31:0] rd);
        int n;
        n = 0;
        htrans <= 2'h2;
        haddr <= a;
        hwrite <= w;
        do begin @(posedge hclk); n++; end while (hreadyout !== 1'b1 && n < 20);
        htrans <= 2'h0;
        hwdata <= d;
        do begin @(posedge hclk); n++; end while (hreadyout !== 1'b1 && n < 40);
        rd = hrdata;
        if (n >= 40) begin
            miscompares++;
            complete_run();
        end
    endtask : ahb
    // Write and update the model
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        ahb(1'b1, a, d, r);
        if (a < 8'h20) m[a[4:2]] = d & mk[a[4:2]];
    endtask : wr
    // Read and compare with the model; unmapped reads give zero
    task automatic rd_chk(input logic [7:0] a);
        ahb(1'b0, a, 32'h0, r);
        chk($sformatf("reg_%0h", a), r, (a < 8'h20) ? m[a[4:2]] : 32'h0);
    endtask : rd_chk
    // Predict pad drive and pin read for plain port pins, then compare
    task automatic pads_chk();
        logic [16:0] dig, oe, pu, v, x;
        dig = m[1][16:0];
        v = m[3][16:0];
        oe = m[0][0] ? dig & (m[2][16:0] | ~v) : 17'h0;
        pu = ~oe & {17{~m[0][1]}} & (dig | {17{~m[0][0]}});
        x = 17'($urandom());
        ext_val <= x;
        ext_oe <= ~oe;
        repeat (4) @(posedge hclk);
        chk("pad_oe", pad.oe, oe);
        chk("pad_out", pad.out & oe, v & oe);
        chk("pad_pu", pad.pu, pu);
        ahb(1'b0, 8'h10, 32'h0, r);
        chk("pin_read", r, dig & ((oe & v) | (~oe & x)));
    endtask : pads_chk
    // -------------------------------------------------------------------------
    // Main sequence
    // -------------------------------------------------------------------------
    initial begin
        m = '{32'h0, 32'h1FFFF, 32'h0, 32'h1FFFF, 32'h0, 32'h0, 32'h0, 32'h0};
        {hresetn, hsel, hwrite, haddr, htrans, hwdata} = '0;
        hsize = 3'h2;
        {dbg_active, dbg_out, dbg_oe, ext_val, ext_oe} = '0;
        res_drv = '0;
        miscompares = 0;
        num_checks = 0;
        void'($urandom(32'h7012));
        repeat (3) @(posedge hclk);
        hresetn <= 1'b1;
        hsel <= 1'b1;
        // Reset values, unmapped read
        for (int i = 0; i < 9; i++) if (i != 4) rd_chk(8'(i * 4));
        pads_chk();
        // Random modes, pull-up disable, analog pins
        for (int k = 0; k < 8; k++) begin
            wr(8'h00, 32'h1 | (32'($urandom()) & 32'h2));
            wr(8'h04, $urandom());
            wr(8'h08, $urandom());
            wr(8'h0C, $urandom());
            pads_chk();
        end
        wr(8'h10, 32'hFFFFFFFF);
        for (int i = 0; i < 8; i++) if (i != 4) rd_chk(8'(i * 4));
        // Crossbar: serial port and two resources, receive pin open drain, then a skip
        wr(8'h04, 32'h1FFFF);
        wr(8'h08, 32'h1FFDF);
        wr(8'h18, 32'h7);
        res_drv <= '{out: 16'($urandom()), oe: 16'($urandom())};
        ext_val <= 17'($urandom());
        ext_oe <= 17'h00020;
        repeat (6) @(posedge hclk);
        chk("tx_pin", {pad.oe[4], pad.out[4]}, {1'b1, res_drv.out[0] | ~res_drv.oe[0]});
        chk("res_pin", {pad.oe[0], pad.out[0]}, {1'b1, res_drv.out[1] | ~res_drv.oe[1]});
        chk("res2_pin", {pad.oe[1], pad.out[1]}, {1'b1, res_drv.out[2] | ~res_drv.oe[2]});
        chk("rx_level", uart_rx, ext_val[5]);
        chk("res_in", res_in[1], pad_lvl[0]);
        ahb(1'b0, 8'h10, 32'h0, r);
        chk("read_routed", r & 32'h31, {15'h0, pad_lvl} & 32'h31);
        wr(8'h14, 32'h1);
        repeat (4) @(posedge hclk);
        chk("skip_pin", {pad.oe[1], pad.out[1]}, {1'b1, res_drv.out[1] | ~res_drv.oe[1]});
        // Debug link drives the port 2 pin
        dbg_active <= 1'b1;
        dbg_oe <= 1'b1;
        dbg_out <= 1'($urandom());
        repeat (4) @(posedge hclk);
        chk("debug_pin", {pad.oe[16], pad.out[16]}, {1'b1, dbg_out});
        complete_run();
    end
    // Watchdog against a hang
    initial begin
        #400000;
        miscompares++;
        complete_run();
    end
endmodule : tb_top
